// >>> verilog/rxs_pkg.sv
// rxs_pkg: constants and types for the reset and exception sequencer
// assumes: one 250 MHz core clock, byte-wide program memory
package rxs_pkg;
  // reset vector location in program memory
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam logic [15:0] RESET_VEC_ADDR_LO = 16'h0001;
  // least hold of the reset input during operation, in system clocks
  localparam int RESET_HOLD_CYCLES = 10;
  // interrupt mask bit position and value loaded by reset
  localparam int CCR_IMASK_BIT = 7;
  localparam logic [7:0] CCR_RESET_VAL = 8'h80;
  localparam logic [15:0] SP_RESET_VAL = 16'h0000;
  // length of the RxsInit phase in cycles; the peripheral initialise pulse also covers RxsReset
  localparam logic [3:0] INIT_CYCLES = 4'h2;

  typedef enum logic [2:0] {
    RxsReset, RxsInit, RxsVecHi, RxsVecLo, RxsFirst, RxsRun, RxsIrqEntry
  } rxs_state_t;
endpackage : rxs_pkg

// >>> verilog/rxs_sync.sv
// rxs_sync: two-flop synchroniser for the reset input
// assumes: input may change at any time relative to core_clk
`timescale 1ns/10ps
module rxs_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : rxs_sync

// >>> verilog/rxs_sequencer.sv
// rxs_sequencer: reset and exception sequencing for the cpu core
// assumes: memory answers a read one cycle after memRdEn, cpu reports
// instruction boundaries, interrupt controller holds irqReq level
//
// What this block does
// - a low reset input halts all processing and holds the reset state.
// - reset initialises cpu and peripherals and sets the interrupt mask.
// - the pc is loaded from the vector at 0000-0001, then fetching starts.
// - reset outranks interrupts in the state machine, but irqAccept is not gated by reset; its handling starts at release.
// - an interrupt waits for the current instruction or exception to end.
// - after reset the first instruction always runs before any interrupt.
// - with the mask bit set no maskable interrupt is accepted.
`timescale 1ns/10ps
module rxs_sequencer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic [7:0] memRdData,
  input wire logic instrDone,
  input wire logic irqReq,
  input wire logic irqEntryDone,
  input wire logic ccrWrEn,
  input wire logic [7:0] ccrWrData,
  output logic [15:0] memAddr,
  output logic memRdEn,
  output logic cpuHalt,
  output logic periphInit,
  output logic fetchStart,
  output logic irqAccept,
  output logic [15:0] pcLoad_q,
  output logic [7:0] condition_codes_reg,
  output logic [15:0] stack_pointer_reg
);
  // ---------------------------------------------------------------
  // reset input synchroniser
  // ---------------------------------------------------------------
  logic resetInSync;

  rxs_sync uSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(reset_in_n),
    .syncOut(resetInSync)
  );

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  rxs_pkg::rxs_state_t state_q;
  logic [3:0] initCnt_q;
  logic imask;
  logic irqTake;

  assign imask = condition_codes_reg[rxs_pkg::CCR_IMASK_BIT];
  // accept only at a boundary, unmasked, in normal running
  assign irqTake = (state_q == rxs_pkg::RxsRun) && instrDone && irqReq
                   && !imask;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= rxs_pkg::RxsReset;
    end else if (!resetInSync) begin
      state_q <= rxs_pkg::RxsReset;
    end else begin
      unique case (state_q)
        rxs_pkg::RxsReset: state_q <= rxs_pkg::RxsInit;
        rxs_pkg::RxsInit: begin
          if (initCnt_q == 4'h1) begin
            state_q <= rxs_pkg::RxsVecHi;
          end
        end
        rxs_pkg::RxsVecHi: state_q <= rxs_pkg::RxsVecLo;
        rxs_pkg::RxsVecLo: state_q <= rxs_pkg::RxsFirst;
        rxs_pkg::RxsFirst: begin
          if (instrDone) begin
            state_q <= rxs_pkg::RxsRun;
          end
        end
        rxs_pkg::RxsRun: begin
          if (irqTake) begin
            state_q <= rxs_pkg::RxsIrqEntry;
          end
        end
        rxs_pkg::RxsIrqEntry: begin
          if (irqEntryDone) begin
            state_q <= rxs_pkg::RxsRun;
          end
        end
        default: state_q <= rxs_pkg::RxsReset;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // init counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      initCnt_q <= 4'h0;
    end else if (state_q == rxs_pkg::RxsReset) begin
      initCnt_q <= rxs_pkg::INIT_CYCLES;
    end else if (state_q == rxs_pkg::RxsInit && initCnt_q != 4'h0) begin
      initCnt_q <= initCnt_q - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // vector fetch and pc load
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pcLoad_q <= 16'h0000;
    end else if (state_q == rxs_pkg::RxsVecLo) begin
      pcLoad_q[15:8] <= memRdData;
    end else if (state_q == rxs_pkg::RxsFirst && memRdEn == 1'b0
                 && fetchStart) begin
      pcLoad_q[7:0] <= memRdData;
    end
  end

  // low byte read lands one cycle after the RxsVecLo read
  logic loPending_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loPending_q <= 1'b0;
    end else begin
      loPending_q <= (state_q == rxs_pkg::RxsVecLo) && resetInSync;
    end
  end

  assign memRdEn = (state_q == rxs_pkg::RxsVecHi)
                   || (state_q == rxs_pkg::RxsVecLo);
  assign memAddr = (state_q == rxs_pkg::RxsVecLo) ?
                   rxs_pkg::RESET_VEC_ADDR_LO : rxs_pkg::RESET_VEC_ADDR;
  assign fetchStart = loPending_q && (state_q == rxs_pkg::RxsFirst);
  assign cpuHalt = (state_q == rxs_pkg::RxsReset)
                   || (state_q == rxs_pkg::RxsInit)
                   || (state_q == rxs_pkg::RxsVecHi)
                   || (state_q == rxs_pkg::RxsVecLo);
  assign periphInit = (state_q == rxs_pkg::RxsReset)
                      || (state_q == rxs_pkg::RxsInit);
  assign irqAccept = irqTake;

  // ---------------------------------------------------------------
  // condition codes and stack pointer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      condition_codes_reg <= rxs_pkg::CCR_RESET_VAL;
    end else if (periphInit) begin
      condition_codes_reg <= rxs_pkg::CCR_RESET_VAL;
    end else if (irqTake) begin
      condition_codes_reg[rxs_pkg::CCR_IMASK_BIT] <= 1'b1;
    end else if (ccrWrEn) begin
      condition_codes_reg <= ccrWrData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_pointer_reg <= rxs_pkg::SP_RESET_VAL;
    end else if (periphInit) begin
      stack_pointer_reg <= rxs_pkg::SP_RESET_VAL;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_halt_in_reset: assert property (
    @(posedge core_clk) disable iff (rst)
    !resetInSync |=> cpuHalt && state_q == rxs_pkg::RxsReset)
    else $error("not halted while reset held");
  a_periph_held: assert property (
    @(posedge core_clk) disable iff (rst)
    !resetInSync |=> periphInit && !memRdEn && !fetchStart)
    else $error("processing went on while reset held");
  a_mask_on_init: assert property (
    @(posedge core_clk) disable iff (rst)
    periphInit |=> imask)
    else $error("mask not set by reset");
  // init phase lasts INIT_CYCLES, two clocks
  a_init_length: assert property (
    @(posedge core_clk) disable iff (rst || !resetInSync)
    state_q == rxs_pkg::RxsReset && resetInSync |=>
    state_q == rxs_pkg::RxsInit [*2] ##1 state_q == rxs_pkg::RxsVecHi)
    else $error("initialise phase has wrong length");
  a_hi_byte_first: assert property (
    @(posedge core_clk) disable iff (rst)
    state_q == rxs_pkg::RxsVecHi |->
    memRdEn && memAddr == rxs_pkg::RESET_VEC_ADDR)
    else $error("vector high byte not read first");
  a_vec_read_order: assert property (
    @(posedge core_clk) disable iff (rst)
    state_q == rxs_pkg::RxsVecHi && resetInSync |=>
    memRdEn && memAddr == rxs_pkg::RESET_VEC_ADDR_LO)
    else $error("vector low byte not read next");
  a_pc_from_vec: assert property (
    @(posedge core_clk) disable iff (rst)
    fetchStart |=> pcLoad_q == {$past(memRdData, 2), $past(memRdData)})
    else $error("pc not loaded from vector");
  a_release_start: assert property (
    @(posedge core_clk) disable iff (rst)
    state_q == rxs_pkg::RxsReset && resetInSync |=>
    state_q == rxs_pkg::RxsInit)
    else $error("handling did not start on release");
  a_irq_boundary: assert property (
    @(posedge core_clk) disable iff (rst)
    irqAccept |-> instrDone && state_q == rxs_pkg::RxsRun)
    else $error("interrupt taken off boundary");
  a_first_unmasked: assert property (
    @(posedge core_clk) disable iff (rst)
    fetchStart |-> !irqAccept ##1 !irqAccept)
    else $error("interrupt before first instruction");
  a_first_to_run: assert property (
    @(posedge core_clk) disable iff (rst)
    state_q == rxs_pkg::RxsFirst && instrDone && resetInSync |=>
    state_q == rxs_pkg::RxsRun)
    else $error("first instruction did not end the start phase");
  a_mask_blocks: assert property (
    @(posedge core_clk) disable iff (rst)
    imask |-> !irqAccept)
    else $error("masked interrupt accepted");
  a_sync_delay: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(reset_in_n) ##1 reset_in_n |=> resetInSync)
    else $error("sync delay wrong");
  c_reset_seq: cover property (@(posedge core_clk) disable iff (rst)
    state_q == rxs_pkg::RxsVecLo ##1 fetchStart);
  c_irq_taken: cover property (@(posedge core_clk) disable iff (rst)
    irqAccept);
  c_irq_masked: cover property (@(posedge core_clk) disable iff (rst)
    irqReq && instrDone && imask && state_q == rxs_pkg::RxsRun);
  c_reset_in_run: cover property (@(posedge core_clk) disable iff (rst)
    state_q == rxs_pkg::RxsRun && !resetInSync);
endmodule : rxs_sequencer

// >>> verif/rxs_reset_src.sv
// rxs_reset_src: outside reset source driving the reset input
// assumes: holdReq is a request pulse or level from the bench
`timescale 1ns/10ps
module rxs_reset_src #(
  parameter int MIN_LOW = rxs_pkg::RESET_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic clkStable,
  input wire logic holdReq,
  output logic reset_in_n
);
  int lowCnt;
  // low until clock is stable, then at least MIN_LOW clocks per request
  always @(posedge core_clk) begin
    if (!clkStable || holdReq) begin
      reset_in_n <= 1'b0;
      lowCnt <= 0;
    end else if (lowCnt < MIN_LOW - 1) begin
      lowCnt <= lowCnt + 1;
    end else begin
      reset_in_n <= 1'b1;
    end
  end
endmodule : rxs_reset_src

// >>> verif/reset_exception_sequencer_tb_top.sv
// reset_exception_sequencer_tb_top: self-checking bench
// assumes: vector memory answers one cycle after memRdEn
`timescale 1ns/10ps
module reset_exception_sequencer_tb_top;
  logic core_clk, rst, clkStable, holdReq, reset_in_n, instrDone, irqReq;
  logic irqEntryDone, ccrWrEn, memRdEn, cpuHalt, periphInit, fetchStart;
  logic irqAccept;
  logic pcDue = 1'b0;
  logic rdIdx = 1'b0;
  logic [7:0] memRdData, ccrWrData, condition_codes_reg;
  logic [7:0] vecMem [2];
  logic [15:0] memAddr, pcLoad_q, stack_pointer_reg;
  logic [15:0] expPc [$];
  int n_fail, samples_checked, cycles, seed, relCnt;
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  rxs_reset_src src (.core_clk(core_clk), .clkStable(clkStable),
    .holdReq(holdReq), .reset_in_n(reset_in_n));
  rxs_sequencer dut (.core_clk(core_clk), .rst(rst),
    .reset_in_n(reset_in_n), .memRdData(memRdData), .instrDone(instrDone),
    .irqReq(irqReq), .irqEntryDone(irqEntryDone), .ccrWrEn(ccrWrEn),
    .ccrWrData(ccrWrData), .memAddr(memAddr), .memRdEn(memRdEn),
    .cpuHalt(cpuHalt), .periphInit(periphInit), .fetchStart(fetchStart),
    .irqAccept(irqAccept), .pcLoad_q(pcLoad_q),
    .condition_codes_reg(condition_codes_reg),
    .stack_pointer_reg(stack_pointer_reg));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic boot();
    int k;
    vecMem[0] = 8'($random(seed));
    vecMem[1] = 8'($random(seed));
    expPc.push_back({vecMem[0], vecMem[1]});
    k = 0;
    while (fetchStart !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    chk("boot", 16'(k < 40), 16'h1);
    tick(2);
  endtask : boot
  task automatic instr(logic exp);
    @(posedge core_clk);
    instrDone <= 1'b1;
    @(negedge core_clk);
    chk("accept", 16'(irqAccept), 16'(exp));
    @(posedge core_clk);
    instrDone <= 1'b0;
  endtask : instr
  task automatic pulse(logic isCcr, logic [7:0] v);
    @(posedge core_clk);
    if (isCcr) ccrWrEn <= 1'b1; else irqEntryDone <= 1'b1;
    ccrWrData <= v;
    @(posedge core_clk);
    ccrWrEn <= 1'b0;
    irqEntryDone <= 1'b0;
  endtask : pulse
  // ------------------------------------------------------------
  // memory model, monitor and timeout
  // ------------------------------------------------------------
  always @(posedge core_clk)
    memRdData <= memRdEn ? vecMem[memAddr[0]] : 8'($random(seed));
  // clocks since the reset input last went high
  always @(posedge core_clk)
    relCnt <= reset_in_n ? relCnt + 1 : 0;
  always @(negedge core_clk) begin
    if (pcDue) begin
      chk("pc", pcLoad_q, expPc.pop_front());
      pcDue = 1'b0;
    end
    if (memRdEn) begin
      chk("addr", memAddr, rdIdx ? rxs_pkg::RESET_VEC_ADDR_LO :
        rxs_pkg::RESET_VEC_ADDR);
      rdIdx = ~rdIdx;
    end
    if (fetchStart) begin
      chk("halt", 16'(cpuHalt), 16'h0);
      // two sync stages, reset exit, init phase, two vector reads
      chk("latency", 16'(relCnt), 16'(5 + rxs_pkg::INIT_CYCLES));
      pcDue = 1'b1;
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hf48ed5af;
    {rst, clkStable, holdReq, instrDone, irqReq} = 5'h10;
    {irqEntryDone, ccrWrEn} = 2'h0;
    {ccrWrData, vecMem[0], vecMem[1]} = 24'h0;
    tick(16);
    rst <= 1'b0;
    irqReq <= 1'b1;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        pulse(1'b0, 8'h00);
        holdReq <= 1'b1;
        tick(1);
        holdReq <= 1'b0;
        tick(4);
        instr(1'b0);
      end
      @(negedge core_clk);
      chk("halt", 16'(cpuHalt), 16'h1);
      chk("init", 16'(periphInit), 16'h1);
      chk("ccr", 16'(condition_codes_reg), 16'h80);
      chk("sp", stack_pointer_reg, rxs_pkg::SP_RESET_VAL);
      clkStable <= 1'b1;
      boot();
      instr(1'b0);
      instr(1'b0);
      pulse(1'b1, 8'h00);
      instr(1'b1);
      @(negedge core_clk);
      chk("mask", 16'(condition_codes_reg[7]), 16'h1);
      pulse(1'b1, 8'h00);
      instr(1'b0);
      pulse(1'b0, 8'h00);
      instr(1'b1);
      pulse(1'b1, 8'h00);
    end
    end_sim();
  end
endmodule : reset_exception_sequencer_tb_top
